// ==== inc/scr_params.svh ====
// Offsets, field positions and reset values of the SYSREF clock control bank
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

// Register byte offsets; the position status spans three bytes
`define SCR_OFS_SYSREF_CTRL 8'h29
`define SCR_OFS_INPUT_MODE 8'h2a
`define SCR_OFS_NOISE_CTRL 8'h2b
`define SCR_OFS_POS_B0 8'h2c
`define SCR_OFS_POS_B1 8'h2d
`define SCR_OFS_POS_B2 8'h2e

// Reset values
`define SCR_RST_SYSREF_CTRL 8'h80
`define SCR_RST_INPUT_MODE 8'h00
`define SCR_RST_NOISE_CTRL 8'h10
`define SCR_RST_POS 24'h000000
`define SCR_RD_UNMAPPED 8'h00

// Fields of the SYSREF clock control register
`define SCR_BIT_PROC_EN 6
`define SCR_BIT_RECV_EN 5
`define SCR_BIT_FINE_SCALE 4
`define SCR_SEL_MSB 3
`define SCR_SEL_LSB 0

// Fields of the clock input mode register
`define SCR_BIT_DEVICE_CLOCK_INPUT_PECL 2
`define SCR_BIT_SYSREF_PECL 1
`define SCR_BIT_INVERT 0

// Fields of the supply noise control register
`define SCR_BIT_ANALOG_SUPPR 2
`define SCR_BIT_CLOCK_SUPPR 0

// Width of the position status
`define SCR_POS_WIDTH 24

`endif

// ==== inc/scr_pkg.sv ====
// Types shared by the SYSREF clock control bank
`default_nettype none
package scr_pkg;
  typedef logic [7:0] scr_byte_t;
  typedef logic [3:0] scr_delay_t;
  typedef enum logic [1:0] {
    SCR_LANE_LOW,
    SCR_LANE_MID,
    SCR_LANE_HIGH
  } scr_lane_e;
endpackage
`default_nettype wire

// ==== rtl/scr_clock_regs.sv ====
// SYSREF clock control register bank with position status
`timescale 1ns/1ps
`default_nettype none
`include "scr_params.svh"
module scr_clock_regs #(
  parameter int ADDR_W = 15,
  parameter int POS_W = 24
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire scr_pkg::scr_byte_t regWdata,
  output scr_pkg::scr_byte_t regRdata,
  output logic regRvalid,
  input wire logic sysrefIn,
  input wire logic [POS_W-1:0] edgePosition,
  output logic sysrefEvent,
  output logic sysrefEventProcessEnable,
  output logic sysrefReceiverEnable,
  output logic sysrefFineWindowScale,
  output scr_pkg::scr_delay_t sysrefDelayChoice,
  output logic sysrefPolarityInvert,
  output logic deviceClockPeclInputMode,
  output logic sysrefPeclInputMode,
  output logic analogRailNoiseSuppress,
  output logic clockRailNoiseSuppress
);
  import scr_pkg::*;

  initial begin
    if (ADDR_W < 8) begin
      $error("ADDR_W must be at least 8");
    end
    if (POS_W != `SCR_POS_WIDTH) begin
      $error("POS_W must be 24");
    end
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  scr_byte_t sysrefCtrl;
  scr_byte_t inputMode;
  scr_byte_t noiseCtrl;
  logic [POS_W-1:0] edgeStatus;
  logic positionCapture;
  scr_lane_e lane;

  // Address decode
  wire hitCtrl = hit(regAddr, `SCR_OFS_SYSREF_CTRL);
  wire hitMode = hit(regAddr, `SCR_OFS_INPUT_MODE);
  wire hitNoise = hit(regAddr, `SCR_OFS_NOISE_CTRL);
  wire hitPos0 = hit(regAddr, `SCR_OFS_POS_B0);
  wire hitPos1 = hit(regAddr, `SCR_OFS_POS_B1);
  wire hitPos2 = hit(regAddr, `SCR_OFS_POS_B2);
  wire hitPos = hitPos0 | hitPos1 | hitPos2;
  wire wrCtrl = regWrite & hitCtrl;
  wire wrMode = regWrite & hitMode;
  wire wrNoise = regWrite & hitNoise;

  assign lane = hitPos2 ? SCR_LANE_HIGH : (hitPos1 ? SCR_LANE_MID : SCR_LANE_LOW);

  scr_byte_t posByte;
  always_comb begin
    posByte = edgeStatus[7:0];
    unique case (lane)
      SCR_LANE_LOW: posByte = edgeStatus[7:0];
      SCR_LANE_MID: posByte = edgeStatus[15:8];
      SCR_LANE_HIGH: posByte = edgeStatus[23:16];
    endcase
  end

  wire scr_byte_t next_rdata = hitCtrl ? sysrefCtrl :
                               hitMode ? inputMode :
                               hitNoise ? noiseCtrl :
                               hitPos ? posByte : `SCR_RD_UNMAPPED;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sysrefCtrl <= `SCR_RST_SYSREF_CTRL;
    end else if (wrCtrl) begin
      sysrefCtrl <= regWdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      inputMode <= `SCR_RST_INPUT_MODE;
    end else if (wrMode) begin
      inputMode <= regWdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      noiseCtrl <= `SCR_RST_NOISE_CTRL;
    end else if (wrNoise) begin
      noiseCtrl <= regWdata;
    end
  end

  // read port has no side effects
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      regRdata <= `SCR_RD_UNMAPPED;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        regRdata <= next_rdata;
      end
    end
  end

  assign sysrefEventProcessEnable = sysrefCtrl[`SCR_BIT_PROC_EN];
  assign sysrefReceiverEnable = sysrefCtrl[`SCR_BIT_RECV_EN];
  assign sysrefFineWindowScale = sysrefCtrl[`SCR_BIT_FINE_SCALE];
  assign sysrefDelayChoice = sysrefCtrl[`SCR_SEL_MSB:`SCR_SEL_LSB];
  assign sysrefPolarityInvert = inputMode[`SCR_BIT_INVERT];
  assign deviceClockPeclInputMode = inputMode[`SCR_BIT_DEVICE_CLOCK_INPUT_PECL];
  assign sysrefPeclInputMode = inputMode[`SCR_BIT_SYSREF_PECL];
  assign analogRailNoiseSuppress = noiseCtrl[`SCR_BIT_ANALOG_SUPPR];
  assign clockRailNoiseSuppress = noiseCtrl[`SCR_BIT_CLOCK_SUPPR];

  // status comes only from the detector, never the bus
  scr_sysref_gate #(
    .POS_W(POS_W)
  ) u_gate (
    .mclk(mclk),
    .nrst(nrst),
    .sysrefIn(sysrefIn),
    .polarityInvert(sysrefPolarityInvert),
    .receiverEnable(sysrefReceiverEnable),
    .processEnable(sysrefEventProcessEnable),
    .edgePosition(edgePosition),
    .sysrefEvent(sysrefEvent),
    .positionCapture(positionCapture),
    .capturedPosition(edgeStatus)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // Reset checks must see the reset itself, so they bypass the default
  a_ctrl_reset: assert property (@(posedge mclk) disable iff (1'b0)
    !nrst |=> sysrefCtrl == `SCR_RST_SYSREF_CTRL && !sysrefReceiverEnable)
    else $error("control register not at reset value");

  a_mode_reset: assert property (@(posedge mclk) disable iff (1'b0)
    !nrst |=> inputMode == `SCR_RST_INPUT_MODE)
    else $error("input mode register not cleared by reset");

  a_noise_reset: assert property (@(posedge mclk) disable iff (1'b0)
    !nrst |=> noiseCtrl == `SCR_RST_NOISE_CTRL && !clockRailNoiseSuppress)
    else $error("noise register not at reset value");

  a_proc_gate: assert property (
    !$past(sysrefEventProcessEnable) |-> !sysrefEvent)
    else $error("SYSREF event while processor disabled");

  a_event_edge: assert property (
    sysrefReceiverEnable && sysrefEventProcessEnable && !sysrefPolarityInvert
    && !sysrefIn ##1 sysrefIn && $stable(inputMode) && $stable(sysrefCtrl) |=> sysrefEvent)
    else $error("rising SYSREF edge produced no event");

  a_delay_write: assert property (
    wrCtrl |=> sysrefDelayChoice == $past(regWdata[3:0])
    && sysrefFineWindowScale == $past(regWdata[4]))
    else $error("delay choice not taken from write");

  a_noise_write: assert property (
    wrNoise |=> analogRailNoiseSuppress == $past(regWdata[2])
    && clockRailNoiseSuppress == $past(regWdata[0]))
    else $error("noise suppression bits not updated");

  a_mode_write: assert property (
    wrMode |=> deviceClockPeclInputMode == $past(regWdata[2])
    && sysrefPeclInputMode == $past(regWdata[1]))
    else $error("input mode bits not updated");

  a_status_ro: assert property (
    regWrite && hitPos && !positionCapture ##1 !positionCapture |-> $stable(edgeStatus))
    else $error("position status changed by a write");

  a_pos_read: assert property (
    regRead && hitPos2 |=> regRvalid && regRdata == $past(edgeStatus[23:16]))
    else $error("position high byte read wrong");

  a_recv_capture: assert property (
    !sysrefReceiverEnable ##1 !sysrefReceiverEnable |-> !positionCapture)
    else $error("position captured with receiver off");

  c_event_seen: cover property (sysrefEvent);
  c_pos_read: cover property (positionCapture ##[1:20] (regRead && hitPos0));
  c_ctrl_enable: cover property (wrCtrl && regWdata[5] ##[1:10] wrCtrl && regWdata[6]);
endmodule
`default_nettype wire

// ==== rtl/scr_sysref_gate.sv ====
// SYSREF polarity, receiver gating, event detection and edge position capture
`timescale 1ns/1ps
`default_nettype none
`include "scr_params.svh"
module scr_sysref_gate #(
  parameter int POS_W = 24
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sysrefIn,
  input wire logic polarityInvert,
  input wire logic receiverEnable,
  input wire logic processEnable,
  input wire logic [POS_W-1:0] edgePosition,
  output logic sysrefEvent,
  output logic positionCapture,
  output logic [POS_W-1:0] capturedPosition
);
  initial begin
    if (POS_W < 1) begin
      $error("POS_W must be at least one");
    end
  end

  logic sysrefPrev;
  wire sysrefAligned = sysrefIn ^ polarityInvert;
  wire sysrefSeen = sysrefAligned & receiverEnable;
  wire risingEdge = sysrefSeen & ~sysrefPrev;
  wire next_event = risingEdge & processEnable;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sysrefPrev <= 1'b0;
      sysrefEvent <= 1'b0;
      positionCapture <= 1'b0;
    end else begin
      sysrefPrev <= sysrefSeen;
      sysrefEvent <= next_event;
      positionCapture <= risingEdge;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      capturedPosition <= POS_W'(`SCR_RST_POS);
    end else if (risingEdge) begin
      capturedPosition <= edgePosition;
    end
  end
endmodule
`default_nettype wire

// ==== test/scr_sysref_src.sv ====
// System clock generator model that launches SYSREF pulses
`timescale 1ns/1ps
`default_nettype none
module scr_sysref_src (
  input wire logic mclk,
  input wire logic fire,
  input wire logic [23:0] pos,
  output logic sysrefIn,
  output logic [23:0] edgePosition
);
  logic [1:0] cnt = 2'h0;
  initial sysrefIn = 1'b0;
  initial edgePosition = 24'h0;
  // Pulse is two cycles high; position is scrambled once it drops
  always @(posedge mclk) begin
    if (fire) begin
      cnt <= 2'h2;
      sysrefIn <= 1'b1;
      edgePosition <= pos;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
      if (cnt == 2'h1) begin
        sysrefIn <= 1'b0;
        edgePosition <= ~edgePosition;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/sysref_clock_control_regs_tb.sv ====
// Self-checking bench for the SYSREF clock control bank
`timescale 1ns/1ps
`default_nettype none
module sysref_clock_control_regs_tb;
  import scr_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0, fire = 1'b0;
  logic [14:0] regAddr = 15'h0;
  scr_byte_t regWdata = 8'h0;
  scr_byte_t regRdata;
  scr_delay_t sysrefDelayChoice;
  logic [23:0] pos = 24'h0;
  logic [23:0] edgePosition;
  logic regRvalid, sysrefIn, sysrefEvent, sysrefEventProcessEnable, sysrefReceiverEnable;
  logic sysrefFineWindowScale, sysrefPolarityInvert, deviceClockPeclInputMode;
  logic sysrefPeclInputMode, analogRailNoiseSuppress, clockRailNoiseSuppress;
  int mismatches = 0, compares = 0, evCount = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (sysrefEvent === 1'b1) evCount <= evCount + 1;
  scr_clock_regs #(.ADDR_W(15), .POS_W(24)) dut (.mclk, .nrst, .regAddr, .regWrite,
    .regRead, .regWdata, .regRdata, .regRvalid, .sysrefIn, .edgePosition, .sysrefEvent,
    .sysrefEventProcessEnable, .sysrefReceiverEnable, .sysrefFineWindowScale,
    .sysrefDelayChoice, .sysrefPolarityInvert, .deviceClockPeclInputMode,
    .sysrefPeclInputMode, .analogRailNoiseSuppress, .clockRailNoiseSuppress);
  scr_sysref_src src (.mclk, .fire, .pos, .sysrefIn, .edgePosition);
  task automatic report_and_stop;
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= {7'h0, a};
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    #1;
  endtask
  // Answer comes exactly one cycle after the read is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= {7'h0, a};
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk({23'h0, regRvalid}, 24'h1);
    chk({16'h0, regRdata}, {16'h0, e});
  endtask
  task automatic rdpos(input logic [23:0] e);
    rd(8'h2c, e[7:0]);
    rd(8'h2d, e[15:8]);
    rd(8'h2e, e[23:16]);
  endtask
  task automatic pulse(input logic [23:0] p);
    @(posedge mclk);
    pos <= p;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
  endtask
  task automatic t_reset;
    rd(8'h29, 8'h80);
    rd(8'h2a, 8'h00);
    rd(8'h2b, 8'h10);
    rdpos(24'h0);
    rd(8'h40, 8'h00);
    chk({sysrefEventProcessEnable, sysrefReceiverEnable, sysrefFineWindowScale}, 24'h0);
  endtask
  task automatic t_ctrl;
    logic [7:0] cv [4];
    cv = '{8'ha0, 8'hfa, 8'hbf, 8'h80};
    // Processor and receiver enables each follow their own bit of the written value
    foreach (cv[i]) begin
      wr(8'h29, cv[i]);
      chk({sysrefEventProcessEnable, sysrefReceiverEnable, sysrefFineWindowScale,
        sysrefDelayChoice}, {17'h0, cv[i][6:0]});
      rd(8'h29, cv[i]);
    end
  endtask
  task automatic t_mode;
    for (int i = 0; i < 3; i++) begin
      wr(8'h2a, 8'h1 << i);
      chk({deviceClockPeclInputMode, sysrefPeclInputMode, sysrefPolarityInvert},
        24'h1 << i);
    end
    wr(8'h2a, 8'h00);
    wr(8'h2b, 8'h14);
    chk({analogRailNoiseSuppress, clockRailNoiseSuppress}, 24'h2);
    wr(8'h2b, 8'h11);
    chk({analogRailNoiseSuppress, clockRailNoiseSuppress}, 24'h1);
    rd(8'h2b, 8'h11);
    wr(8'h2b, 8'h10);
  endtask
  task automatic t_sysref;
    wr(8'h29, 8'ha0);
    evCount = 0;
    pulse(24'h123456);
    chk(evCount[23:0], 24'h0);
    rdpos(24'h123456);
    wr(8'h29, 8'he0);
    evCount = 0;
    pulse(24'habcdef);
    chk(evCount[23:0], 24'h1);
    rdpos(24'habcdef);
    wr(8'h29, 8'h80);
    pulse(24'h555555);
    chk(evCount[23:0], 24'h1);
    rdpos(24'habcdef);
    wr(8'h29, 8'he0);
    wr(8'h2a, 8'h01);
    repeat (3) @(posedge mclk);
    #1;
    evCount = 0;
    // Inverted, the falling input edge is the one that counts
    pulse(24'h0f0f0f);
    chk(evCount[23:0], 24'h1);
    rdpos(24'hf0f0f0);
    wr(8'h2a, 8'h00);
  endtask
  task automatic t_ro;
    wr(8'h2c, 8'hff);
    wr(8'h2d, 8'hff);
    wr(8'h2e, 8'hff);
    rdpos(24'hf0f0f0);
    rdpos(24'hf0f0f0);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_ctrl();
    t_mode();
    t_sysref();
    t_ro();
    report_and_stop();
  end
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
